/* design/ciu_core_irq.sv */
// core interrupt unit: global enable, pin requests and flags, priority entry and return sequencing
`timescale 1ns/10ps
`default_nettype none

module ciu_core_irq (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ciu_pkg::ciu_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic [2:0] ext_pin,
  input wire logic [ciu_pkg::NSRC-1:0] periph_req,
  output logic [ciu_pkg::NSRC-1:0] periph_ack,
  input wire logic [ciu_pkg::PC_W-1:0] boot_vector_base,
  input wire ciu_pkg::ciu_core_in_t core_in,
  output ciu_pkg::ciu_core_out_t core_out,
  output logic global_enable,
  output logic [ciu_pkg::PC_W-1:0] pc_push_value,
  input wire logic [ciu_pkg::PC_W-1:0] core_pc
);

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] flags_r;
  logic [7:0] sense_r;
  logic gie_r;
  logic [2:0] pin_prev_r;
  logic [2:0] unlock_cnt_r;
  logic block_r;
  logic block_tail_r;
  logic [2:0] seq_cnt_r;
  logic [2:0] seq_cnt_nxt;
  logic [3:0] win_id_r;
  ciu_pkg::ciu_state_t state_r;
  ciu_pkg::ciu_state_t state_nxt;

  // combinational decode and selection
  logic wr_ctrl;
  logic wr_flags;
  logic wr_sense;
  logic [2:0] pin_event;
  logic [2:0] level_req;
  logic [2:0] pin_en;
  logic [ciu_pkg::NSRC-1:0] pending;
  logic [3:0] win_id;
  logic any_pending;
  logic accept;
  logic [2:0] hw_clear;
  logic sel_write_ok;
  logic [1:0] s0;
  logic [1:0] s1;

  // decode is combinational, so a write lands at the very edge that samples its strobe
  // unmapped addresses decode to nothing: such writes are dropped without a trace
  assign wr_ctrl = bus_req.wr && (bus_req.addr == ciu_pkg::CTRL_OFFSET);
  assign wr_flags = bus_req.wr && (bus_req.addr == ciu_pkg::FLAGS_OFFSET);
  assign wr_sense = bus_req.wr && (bus_req.addr == ciu_pkg::SENSE_OFFSET);
  assign s0 = {sense_r[ciu_pkg::S0_HI_BIT], sense_r[ciu_pkg::S0_LO_BIT]};
  assign s1 = {sense_r[ciu_pkg::S1_HI_BIT], sense_r[ciu_pkg::S1_LO_BIT]};
  assign pin_en = {ctrl_r[ciu_pkg::EN2_BIT], ctrl_r[ciu_pkg::EN1_BIT], ctrl_r[ciu_pkg::EN0_BIT]};
  assign sel_write_ok = wr_ctrl && ctrl_r[ciu_pkg::UNLOCK_BIT] && !bus_req.wdata[ciu_pkg::UNLOCK_BIT];

  // ----------------------------------------------------------------
  // pin sensing
  // ----------------------------------------------------------------
  // pins are sampled after the pad, so an output-driven pin still triggers
  // the history resets low while sense resets to level (pin 2 to falling edge), so no false edge follows reset
  // limitation: a pulse shorter than one clock period may go unseen
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_prev_r <= 3'h0;
    end else begin
      pin_prev_r <= ext_pin;
    end
  end

  // level mode yields no edge here and never reaches a flag
  function automatic logic edge_hit(input logic [1:0] mode, input logic now, input logic was);
    case (mode)
      ciu_pkg::SENSE_ANY: edge_hit = now ^ was;
      ciu_pkg::SENSE_FALL: edge_hit = was & ~now;
      ciu_pkg::SENSE_RISE: edge_hit = now & ~was;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  always_comb begin
    pin_event[0] = edge_hit(s0, ext_pin[0], pin_prev_r[0]);
    pin_event[1] = edge_hit(s1, ext_pin[1], pin_prev_r[1]);
    pin_event[2] = sense_r[ciu_pkg::S2_EDGE_BIT] ? (ext_pin[2] & ~pin_prev_r[2])
                                                 : (pin_prev_r[2] & ~ext_pin[2]);
    level_req[0] = (s0 == ciu_pkg::SENSE_LEVEL) && !ext_pin[0];
    level_req[1] = (s1 == ciu_pkg::SENSE_LEVEL) && !ext_pin[1];
    level_req[2] = 1'b0;
  end

  // ----------------------------------------------------------------
  // flags: pin flags in bits 7..5, set beats clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags_r <= ciu_pkg::FLAGS_RESET;
    end else begin
      // an event in the cycle of a clear wins, so no edge is lost to a racing write
      flags_r[ciu_pkg::FLAG0_BIT] <= (s0 != ciu_pkg::SENSE_LEVEL) && (pin_event[0] ||
        (flags_r[ciu_pkg::FLAG0_BIT] && !hw_clear[0] && !(wr_flags && bus_req.wdata[ciu_pkg::FLAG0_BIT])));
      flags_r[ciu_pkg::FLAG1_BIT] <= (s1 != ciu_pkg::SENSE_LEVEL) && (pin_event[1] ||
        (flags_r[ciu_pkg::FLAG1_BIT] && !hw_clear[1] && !(wr_flags && bus_req.wdata[ciu_pkg::FLAG1_BIT])));
      // pin 2 has no level mode, so its flag is never held clear
      flags_r[ciu_pkg::FLAG2_BIT] <= pin_event[2] ||
        (flags_r[ciu_pkg::FLAG2_BIT] && !hw_clear[2] && !(wr_flags && bus_req.wdata[ciu_pkg::FLAG2_BIT]));
      flags_r[4:0] <= 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // control register and vector relocation unlock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= ciu_pkg::CTRL_RESET;
      unlock_cnt_r <= 3'h0;
    end else begin
      ctrl_r[ciu_pkg::EN1_BIT] <= wr_ctrl ? bus_req.wdata[ciu_pkg::EN1_BIT] : ctrl_r[ciu_pkg::EN1_BIT];
      ctrl_r[ciu_pkg::EN0_BIT] <= wr_ctrl ? bus_req.wdata[ciu_pkg::EN0_BIT] : ctrl_r[ciu_pkg::EN0_BIT];
      ctrl_r[ciu_pkg::EN2_BIT] <= wr_ctrl ? bus_req.wdata[ciu_pkg::EN2_BIT] : ctrl_r[ciu_pkg::EN2_BIT];
      ctrl_r[4:2] <= 3'h0;
      // a select write without a live unlock is simply ignored
      if (sel_write_ok) begin
        ctrl_r[ciu_pkg::VSEL_BIT] <= bus_req.wdata[ciu_pkg::VSEL_BIT];
      end
      // a fresh unlock write restarts the window rather than extending the old one
      if (wr_ctrl && bus_req.wdata[ciu_pkg::UNLOCK_BIT]) begin
        ctrl_r[ciu_pkg::UNLOCK_BIT] <= 1'b1;
        unlock_cnt_r <= ciu_pkg::UNLOCK_CYCLES;
      end else if (sel_write_ok || unlock_cnt_r == 3'h1) begin
        ctrl_r[ciu_pkg::UNLOCK_BIT] <= 1'b0;
        unlock_cnt_r <= 3'h0;
      end else if (unlock_cnt_r != 3'h0) begin
        unlock_cnt_r <= unlock_cnt_r - 3'h1;
      end
    end
  end

  // interrupts held off while unlocked, and through the instruction after the select write
  // the global enable is left alone: the hold-off is a separate gate on acceptance
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      block_tail_r <= 1'b0;
    end else if (sel_write_ok) begin
      block_tail_r <= 1'b1;
    end else if (core_in.insn_done) begin
      block_tail_r <= 1'b0;
    end
  end

  always_comb begin
    block_r = ctrl_r[ciu_pkg::UNLOCK_BIT] || block_tail_r ||
              (wr_ctrl && bus_req.wdata[ciu_pkg::UNLOCK_BIT]);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sense_r <= ciu_pkg::SENSE_RESET;
    end else if (wr_sense) begin
      // unused sense bits are dropped on write so they read back as zero
      sense_r <= bus_req.wdata & ciu_pkg::SENSE_RW_MASK;
    end
  end

  // ----------------------------------------------------------------
  // read port: data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      // reserved ctrl and flag bits are masked here as well as never being stored; sense is read back unmasked
      case (bus_req.addr)
        ciu_pkg::CTRL_OFFSET: bus_rdata <= ctrl_r & ciu_pkg::CTRL_RW_MASK;
        ciu_pkg::FLAGS_OFFSET: bus_rdata <= flags_r & ciu_pkg::FLAGS_RW_MASK;
        ciu_pkg::SENSE_OFFSET: bus_rdata <= sense_r;
        default: bus_rdata <= 8'h00;
      endcase
    end else begin
      // no read this cycle: the port shows zero so stale data cannot be mistaken
      bus_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // priority select: slot 0 = pin 0, 1 = pin 1, 2 = pin 2, then peripherals
  // ----------------------------------------------------------------
  always_comb begin
    // slots 0..2 belong to the pins and override what the peripheral vector carries
    pending = periph_req;
    pending[0] = pin_en[0] && (flags_r[ciu_pkg::FLAG0_BIT] || level_req[0]);
    pending[1] = pin_en[1] && (flags_r[ciu_pkg::FLAG1_BIT] || level_req[1]);
    pending[2] = pin_en[2] && flags_r[ciu_pkg::FLAG2_BIT];
    // the loop runs downward so the lowest pending slot is the last to win
    win_id = 4'h0;
    any_pending = 1'b0;
    for (int i = ciu_pkg::NSRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        win_id = 4'(i);
        any_pending = 1'b1;
      end
    end
  end

  // pending requests wait for the global enable and an instruction boundary
  // a request arriving mid-instruction simply waits here for the boundary
  assign accept = (state_r == ciu_pkg::ST_RUN) && gie_r && any_pending && !block_r &&
                  core_in.insn_boundary;

  // ----------------------------------------------------------------
  // entry/return sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    seq_cnt_nxt = seq_cnt_r;
    case (state_r)
      ciu_pkg::ST_RUN: begin
        // entry outranks return; a return is only decoded in the run state
        if (accept && core_in.sleeping) begin
          state_nxt = ciu_pkg::ST_WAKE;
          seq_cnt_nxt = ciu_pkg::WAKE_CYCLES;
        end else if (accept) begin
          state_nxt = ciu_pkg::ST_ENTER;
          seq_cnt_nxt = ciu_pkg::ENTRY_CYCLES;
        end else if (core_in.ret_exec) begin
          state_nxt = ciu_pkg::ST_RETURN;
          seq_cnt_nxt = ciu_pkg::RETURN_CYCLES;
        end
      end
      // wake-up is a fixed prelude; take and vector come at its start, the push follows in the entry state
      ciu_pkg::ST_WAKE: begin
        seq_cnt_nxt = seq_cnt_r - 3'h1;
        if (seq_cnt_r == 3'h1) begin
          state_nxt = ciu_pkg::ST_ENTER;
          seq_cnt_nxt = ciu_pkg::ENTRY_CYCLES;
        end
      end
      ciu_pkg::ST_ENTER: begin
        seq_cnt_nxt = seq_cnt_r - 3'h1;
        if (seq_cnt_r == 3'h1) begin
          state_nxt = ciu_pkg::ST_RUN;
        end
      end
      ciu_pkg::ST_RETURN: begin
        seq_cnt_nxt = seq_cnt_r - 3'h1;
        if (seq_cnt_r == 3'h1) begin
          state_nxt = ciu_pkg::ST_ONE_INSN;
        end
      end
      // one main-program instruction must retire before the next entry may start
      ciu_pkg::ST_ONE_INSN: begin
        if (core_in.insn_done) begin
          state_nxt = ciu_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = ciu_pkg::ST_RUN;
        seq_cnt_nxt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ciu_pkg::ST_RUN;
      seq_cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      seq_cnt_r <= seq_cnt_nxt;
    end
  end

  // the winner is frozen at acceptance so the vector cannot change mid-entry
  // the frozen copy lags acceptance by one edge, so outputs at that edge use win_id
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      win_id_r <= 4'h0;
    end else if (accept) begin
      win_id_r <= win_id;
    end
  end

  // the pin flag goes in the last entry cycle, after the pc has already been vectored
  // peripheral slots have no flag here; they are acknowledged instead
  always_comb begin
    hw_clear = 3'h0;
    if (state_r == ciu_pkg::ST_ENTER && seq_cnt_r == 3'h1 && win_id_r < 4'h3) begin
      hw_clear[win_id_r[1:0]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // global enable; the status register itself is left to software
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gie_r <= 1'b0;
    end else if (accept) begin
      gie_r <= 1'b0;
    end else if (state_r == ciu_pkg::ST_RETURN && seq_cnt_r == 3'h1) begin
      gie_r <= 1'b1;
      // software set and clear lose to the hardware events above
    end else if (core_in.gie_clr) begin
      gie_r <= 1'b0;
    end else if (core_in.gie_set) begin
      gie_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // core side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      core_out <= '0;
      pc_push_value <= '0;
      periph_ack <= '0;
    end else begin
      core_out.take <= accept;
      // push marks the first entry cycle, after any wake-up prelude
      core_out.push <= (state_nxt == ciu_pkg::ST_ENTER) && (state_r != ciu_pkg::ST_ENTER);
      core_out.pop <= (state_nxt == ciu_pkg::ST_RETURN) && (state_r != ciu_pkg::ST_RETURN);
      core_out.vector_id <= accept ? win_id : core_out.vector_id;
      // the vector follows the winner from the acceptance edge on, so take and vector agree
      core_out.vector_pc <= (ctrl_r[ciu_pkg::VSEL_BIT] ? boot_vector_base : ciu_pkg::APP_VECTOR_BASE) +
                            ciu_pkg::PC_W'((accept ? win_id : win_id_r) + 4'h1) * ciu_pkg::VECTOR_STEP;
      pc_push_value <= accept ? core_pc : pc_push_value;
      periph_ack <= '0;
      // a peripheral learns its request was served at the end of the last entry cycle
      if (state_r == ciu_pkg::ST_ENTER && seq_cnt_r == 3'h1 && win_id_r >= 4'h3) begin
        periph_ack[win_id_r] <= 1'b1;
      end
    end
  end

  // the core reads this as the enable bit of its status register
  assign global_enable = gie_r;

endmodule : ciu_core_irq

`default_nettype wire

/* design/ciu_pkg.sv */
// package: register map, field positions, sequence timing and types of the core interrupt unit
package ciu_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h3b;
  localparam logic [7:0] FLAGS_OFFSET = 8'h3a;
  localparam logic [7:0] SENSE_OFFSET = 8'h35;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] SENSE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EN1_BIT = 7;
  localparam int EN0_BIT = 6;
  localparam int EN2_BIT = 5;
  localparam int VSEL_BIT = 1;
  localparam int UNLOCK_BIT = 0;
  localparam int FLAG1_BIT = 7;
  localparam int FLAG0_BIT = 6;
  localparam int FLAG2_BIT = 5;
  localparam int S0_LO_BIT = 0;
  localparam int S0_HI_BIT = 1;
  localparam int S1_LO_BIT = 2;
  localparam int S1_HI_BIT = 3;
  localparam int S2_EDGE_BIT = 6;
  localparam logic [7:0] CTRL_RW_MASK = 8'he3;
  localparam logic [7:0] FLAGS_RW_MASK = 8'he0;
  localparam logic [7:0] SENSE_RW_MASK = 8'h4f;

  // ----------------------------------------------------------------
  // sense encodings and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SENSE_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  localparam logic [2:0] ENTRY_CYCLES = 3'h4;
  localparam logic [2:0] WAKE_CYCLES = 3'h4;
  localparam logic [2:0] RETURN_CYCLES = 3'h4;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam int PC_W = 14;
  localparam int NSRC = 16;
  localparam logic [PC_W-1:0] APP_VECTOR_BASE = 14'h0000;
  localparam logic [PC_W-1:0] VECTOR_STEP = 14'h0002;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_ENTER = 5'h02,
    ST_WAKE = 5'h04,
    ST_RETURN = 5'h08,
    ST_ONE_INSN = 5'h10
  } ciu_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ciu_bus_req_t;

  typedef struct packed {
    logic insn_boundary;
    logic insn_done;
    logic ret_exec;
    logic sleeping;
    logic gie_set;
    logic gie_clr;
  } ciu_core_in_t;

  typedef struct packed {
    logic take;
    logic push;
    logic pop;
    logic [PC_W-1:0] vector_pc;
    logic [3:0] vector_id;
  } ciu_core_out_t;

endpackage : ciu_pkg

/* verification/ciu_core_irq_assertions.sv */
// checker: port-level timing properties of the core interrupt unit
`timescale 1ns/10ps
`default_nettype none

module ciu_core_irq_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ciu_pkg::ciu_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic [2:0] ext_pin,
  input wire logic [ciu_pkg::NSRC-1:0] periph_req,
  input wire logic [ciu_pkg::NSRC-1:0] periph_ack,
  input wire logic [ciu_pkg::PC_W-1:0] boot_vector_base,
  input wire ciu_pkg::ciu_core_in_t core_in,
  input wire ciu_pkg::ciu_core_out_t core_out,
  input wire logic global_enable,
  input wire logic [ciu_pkg::PC_W-1:0] pc_push_value,
  input wire logic [ciu_pkg::PC_W-1:0] core_pc
);
  logic [ciu_pkg::PC_W-1:0] voff;
  logic unlock_wr;
  logic per3;
  assign voff = {9'h000, core_out.vector_id, 1'b0} + 14'h0002;
  assign unlock_wr = bus_req.wr && bus_req.addr == ciu_pkg::CTRL_OFFSET && bus_req.wdata[ciu_pkg::UNLOCK_BIT];
  assign per3 = core_out.take && core_out.vector_id == 4'h3;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_take_clr_gie;
    core_out.take |-> !global_enable;
  endproperty
  a_take_clr_gie: assert property (p_take_clr_gie) else $error("enable kept at entry");
  property p_take_gie;
    core_out.take |-> $past(global_enable);
  endproperty
  a_take_gie: assert property (p_take_gie) else $error("entry while disabled");
  property p_take_bound;
    core_out.take |-> $past(core_in.insn_boundary);
  endproperty
  a_take_bound: assert property (p_take_bound) else $error("entry inside instruction");
  property p_push_pc;
    core_out.take |-> pc_push_value == $past(core_pc) && (core_out.push || $past(core_in.sleeping));
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pushed pc wrong");
  property p_vec;
    core_out.take |-> core_out.vector_pc == voff || core_out.vector_pc == boot_vector_base + voff;
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_ack_awake;
    per3 && !core_in.sleeping |-> ##4 periph_ack[3];
  endproperty
  a_ack_awake: assert property (p_ack_awake) else $error("entry length wrong");
  property p_ack_sleep;
    per3 && core_in.sleeping |-> ##8 periph_ack[3];
  endproperty
  a_ack_sleep: assert property (p_ack_sleep) else $error("wake entry length wrong");
  property p_ret_gie;
    core_out.pop |-> ##4 global_enable;
  endproperty
  a_ret_gie: assert property (p_ret_gie) else $error("return did not enable");
  property p_ret_gap;
    core_out.pop |-> !core_out.take [*5];
  endproperty
  a_ret_gap: assert property (p_ret_gap) else $error("entry too soon after return");
  property p_unlock_blk;
    unlock_wr |-> ##2 !core_out.take [*3];
  endproperty
  a_unlock_blk: assert property (p_unlock_blk) else $error("entry during unlock");
  property p_rsv;
    bus_req.rd && bus_req.addr == ciu_pkg::CTRL_OFFSET |=> bus_rdata[4:2] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule : ciu_core_irq_assertions

bind ciu_core_irq ciu_core_irq_assertions u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .ext_pin(ext_pin),
  .periph_req(periph_req), .periph_ack(periph_ack), .boot_vector_base(boot_vector_base),
  .core_in(core_in), .core_out(core_out), .global_enable(global_enable),
  .pc_push_value(pc_push_value), .core_pc(core_pc)
);
`default_nettype wire

/* verification/ciu_core_irq_tb.sv */
// testbench: registers, priority, return and vector relocation of the core interrupt unit
`timescale 1ns/10ps
`default_nettype none

module ciu_core_irq_tb;
  logic clk_sys;
  logic rst_n;
  ciu_pkg::ciu_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  logic [2:0] ext_pin;
  logic [15:0] periph_req;
  logic [15:0] periph_ack;
  logic [13:0] boot_vector_base;
  logic [13:0] pc_push_value;
  logic [13:0] core_pc;
  ciu_pkg::ciu_core_in_t core_in;
  ciu_pkg::ciu_core_out_t core_out;
  logic global_enable;
  logic slow;
  logic sleep;
  logic ret_req;
  logic sei_req;
  logic [7:0] q;
  logic [7:0] offs [4] = '{ciu_pkg::CTRL_OFFSET, ciu_pkg::FLAGS_OFFSET, ciu_pkg::SENSE_OFFSET, 8'h10};
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int tk_cnt = 0;
  int lat = 0;
  int ack_lat = 0;
  integer seed;

  ciu_core_irq DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .ext_pin(ext_pin),
    .periph_req(periph_req), .periph_ack(periph_ack), .boot_vector_base(boot_vector_base),
    .core_in(core_in), .core_out(core_out), .global_enable(global_enable),
    .pc_push_value(pc_push_value), .core_pc(core_pc)
  );
  ciu_core_model u_core (
    .clk_sys(clk_sys), .rst_n(rst_n), .core_out(core_out), .pc_push_value(pc_push_value),
    .slow(slow), .sleep(sleep), .ret_req(ret_req), .sei_req(sei_req), .core_in(core_in), .core_pc(core_pc)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one bus cycle, then one idle cycle so a strobe is never rewritten in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    #1 q = bus_rdata;
    @(posedge clk_sys);
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check({8'h00, q}, {8'h00, e});
  endtask : rd_chk

  task automatic do_ret();
    ret_req <= 1'b1;
    @(posedge clk_sys);
    ret_req <= 1'b0;
  endtask : do_ret

  task automatic expect_take(input int id, input logic [13:0] base);
    int n;
    n = 0;
    #1;
    while (core_out.take !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(16'(core_out.take), 16'h0001);
    check(16'(core_out.vector_id), 16'(id));
    check(16'(core_out.vector_pc), 16'(base + 14'(2 * id + 2)));
    check(16'(global_enable), 16'h0000);
    repeat (6) @(posedge clk_sys);
  endtask : expect_take

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    lat <= core_out.take === 1'b1 ? 0 : lat + 1;
    if (core_out.take === 1'b1) tk_cnt <= tk_cnt + 1;
    if (periph_ack[3] === 1'b1) begin
      periph_req[3] <= 1'b0;
      ack_lat <= lat;
    end
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 45734;
    rst_n = 1'b0;
    bus_req = '0;
    ext_pin = 3'b111;
    periph_req = '0;
    boot_vector_base = 14'($random(seed)) & 14'h3f00;
    slow = 1'b0;
    sleep = 1'b0;
    ret_req = 1'b0;
    sei_req = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (offs[i]) rd_chk(offs[i], 8'h00);
    bus(1'b1, ciu_pkg::CTRL_OFFSET, 8'hfc);
    rd_chk(ciu_pkg::CTRL_OFFSET, 8'he0);
    bus(1'b1, ciu_pkg::CTRL_OFFSET, 8'h00);
    bus(1'b1, ciu_pkg::SENSE_OFFSET, 8'h4f);
    rd_chk(ciu_pkg::SENSE_OFFSET, 8'h4f);
    ext_pin <= 3'b000;
    repeat (2) @(posedge clk_sys);
    ext_pin <= 3'b111;
    repeat (3) @(posedge clk_sys);
    rd_chk(ciu_pkg::FLAGS_OFFSET, 8'he0);
    bus(1'b1, ciu_pkg::FLAGS_OFFSET, 8'h9f);
    rd_chk(ciu_pkg::FLAGS_OFFSET, 8'h60);
    bus(1'b1, ciu_pkg::CTRL_OFFSET, 8'he0);
    repeat (5) @(posedge clk_sys);
    check(16'(tk_cnt), 16'h0000);
    sei_req <= 1'b1;
    @(posedge clk_sys);
    sei_req <= 1'b0;
    expect_take(0, 14'h0000);
    rd_chk(ciu_pkg::FLAGS_OFFSET, 8'h20);
    do_ret();
    expect_take(2, 14'h0000);
    do_ret();
    bus(1'b1, ciu_pkg::SENSE_OFFSET, 8'h43);
    slow <= 1'b1;
    ext_pin[1] <= 1'b0;
    expect_take(1, 14'h0000);
    rd_chk(ciu_pkg::FLAGS_OFFSET, 8'h00);
    ext_pin[1] <= 1'b1;
    do_ret();
    repeat (12) @(posedge clk_sys);
    check(16'(tk_cnt), 16'h0003);
    slow <= 1'b0;
    bus(1'b1, ciu_pkg::CTRL_OFFSET, 8'he1);
    rd_chk(ciu_pkg::CTRL_OFFSET, 8'he1);
    repeat (4) @(posedge clk_sys);
    rd_chk(ciu_pkg::CTRL_OFFSET, 8'he0);
    bus(1'b1, ciu_pkg::CTRL_OFFSET, 8'he1);
    // a request pending across the select write must wait out the following instruction
    periph_req[3] <= 1'b1;
    bus(1'b1, ciu_pkg::CTRL_OFFSET, 8'he2);
    expect_take(3, boot_vector_base);
    check(16'(ack_lat), 16'(ciu_pkg::ENTRY_CYCLES - 3'h1));
    rd_chk(ciu_pkg::CTRL_OFFSET, 8'he2);
    sleep <= 1'b1;
    periph_req[3] <= 1'b1;
    do_ret();
    expect_take(3, boot_vector_base);
    repeat (4) @(posedge clk_sys);
    check(16'(ack_lat), 16'(ciu_pkg::WAKE_CYCLES + ciu_pkg::ENTRY_CYCLES - 3'h1));
    sleep <= 1'b0;
    do_ret();
    repeat (10) @(posedge clk_sys);
    check(16'(global_enable), 16'h0001);
    test_done();
  end
endmodule : ciu_core_irq_tb
`default_nettype wire

/* verification/ciu_core_model.sv */
// partner: behavioural core that steps instructions and keeps the return stack
`timescale 1ns/10ps
`default_nettype none

module ciu_core_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ciu_pkg::ciu_core_out_t core_out,
  input wire logic [ciu_pkg::PC_W-1:0] pc_push_value,
  input wire logic slow,
  input wire logic sleep,
  input wire logic ret_req,
  input wire logic sei_req,
  output ciu_pkg::ciu_core_in_t core_in,
  output logic [ciu_pkg::PC_W-1:0] core_pc
);
  logic [1:0] busy_r;
  logic done_r;
  logic ret_r;
  logic sei_r;
  logic [ciu_pkg::PC_W-1:0] stack_q[$];
  // slow mode runs three-cycle instructions, so entry has to wait for the boundary
  assign core_in = {busy_r == 2'h0, done_r, ret_r, sleep, sei_r, 1'b0};
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_r <= 2'h0;
      done_r <= 1'b0;
      ret_r <= 1'b0;
      sei_r <= 1'b0;
      core_pc <= '0;
      stack_q.delete();
    end else begin
      // handler code saves status itself; the stack holds only the pc
      ret_r <= ret_req;
      sei_r <= sei_req;
      done_r <= busy_r == 2'h1 || (busy_r == 2'h0 && !slow);
      busy_r <= busy_r != 2'h0 ? busy_r - 2'h1 : (slow ? 2'h2 : 2'h0);
      if (core_out.push) begin
        stack_q.push_back(pc_push_value);
      end
      if (core_out.pop && stack_q.size() > 0) begin
        core_pc <= stack_q.pop_back();
      end else if (core_out.take) begin
        core_pc <= core_out.vector_pc;
      end else begin
        core_pc <= core_pc + 14'h0001;
      end
    end
  end
endmodule : ciu_core_model
`default_nettype wire
